// file: hw/mfp_pkg.sv
/*
 * Constants and types for the multifunction pin output selector:
 * function codes, register map, timing counts and the carrier structs.
 * Assumes a single 50 MHz system clock shared with all status sources.
 */
package mfp_pkg;

   // clock and timing
   localparam int CLOCK_MHZ          = 50;
   localparam int WDOG_PULSE_NS      = 40;
   localparam int WDOG_PULSE_CYCLES  = ((WDOG_PULSE_NS * CLOCK_MHZ + 999) / 1000 < 1) ? 1
                                       : (WDOG_PULSE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int WDOG_CNT_W         = $clog2(WDOG_PULSE_CYCLES + 1);
   localparam int CLK_DIV_FACTOR     = 32;
   localparam int CLK_DIV_HALF       = CLK_DIV_FACTOR / 2;
   localparam int DIV_CNT_W          = $clog2(CLK_DIV_HALF);

   // function byte layout
   localparam int DIRECTION_BIT      = 7;
   localparam logic [7:0] FUNC_RESET = 8'h80;

   // output function codes (direction bit set)
   localparam logic [7:0] CODE_LOW        = 8'h80;
   localparam logic [7:0] CODE_HIGH       = 8'h81;
   localparam logic [7:0] CODE_DIV_CLK    = 8'h82;
   localparam logic [7:0] CODE_WDOG       = 8'h83;
   localparam logic [7:0] CODE_NVM_WRITE  = 8'h84;
   localparam logic [7:0] CODE_NVM_READ   = 8'h85;
   localparam logic [7:0] CODE_NVM_FAULT  = 8'h86;
   localparam logic [7:0] CODE_MULT_LOCK  = 8'h88;
   localparam logic [7:0] CODE_MULT_STBL  = 8'h89;
   localparam logic [7:0] CODE_ALL_LOCK   = 8'h8A;
   localparam logic [7:0] CODE_ZERO_LOCK  = 8'h8B;
   localparam logic [7:0] CODE_ONE_LOCK   = 8'h8C;
   localparam logic [7:0] CODE_IRQ_ANY    = 8'h90;
   localparam logic [7:0] CODE_IRQ_SHARED = 8'h91;
   localparam logic [7:0] CODE_IRQ_ZERO   = 8'h92;
   localparam logic [7:0] CODE_IRQ_ONE    = 8'h93;
   localparam logic [4:0] GROUP_REF_FAULT = 5'h14;  // 0xA0..0xA3
   localparam logic [4:0] GROUP_REF_VALID = 5'h15;  // 0xA8..0xAB
   localparam logic [4:0] GROUP_REF_ACT   = 5'h16;  // 0xB0..0xB3
   localparam logic [3:0] GROUP_CHAN_ZERO = 4'hC;   // 0xC0..0xCC
   localparam logic [3:0] GROUP_CHAN_ONE  = 4'hD;   // 0xD0..0xD7
   localparam logic [3:0] CHAN_ZERO_LAST  = 4'hC;
   localparam logic [3:0] CHAN_ONE_LAST   = 4'h7;
   localparam logic [6:0] IN_RESERVED     = 7'h00;

   // register map
   localparam int REG_ADDR_W             = 4;
   localparam logic [3:0] REG_FUNC       = 4'h0;
   localparam logic [3:0] REG_PIN_STATE  = 4'h1;

   // per-channel loop flags
   typedef struct packed {
      logic phase_lock;
      logic freq_lock;
      logic analog_lock;
      logic analog_cal;
      logic active;
      logic free_run;
      logic holdover;
      logic switchover;
      logic history_avail;
      logic history_updated;
      logic clamp_active;
      logic slew_limited;
      logic sync_pulse;
   } chan_status_t;

   // device status feeding the selector
   typedef struct packed {
      logic         nvm_write_busy;
      logic         nvm_read_busy;
      logic         nvm_fault;
      logic         mult_lock;
      logic         mult_stable;
      logic         irq_shared;
      logic         irq_zero;
      logic         irq_one;
      logic [3:0]   ref_fault;
      logic [3:0]   ref_valid;
      logic [3:0]   ref_active_zero;
      logic [3:0]   ref_active_one;
      chan_status_t chan_zero;
      chan_status_t chan_one;
   } dev_status_t;

   // register port request
   typedef struct packed {
      logic [REG_ADDR_W-1:0] addr;
      logic [7:0]            wdata;
      logic                  write;
      logic                  read;
   } reg_req_t;

   // whole state of the selector
   typedef struct packed {
      logic [7:0]            func;
      logic [DIV_CNT_W-1:0]  div_cnt;
      logic                  div_clk;
      logic [WDOG_CNT_W-1:0] wd_cnt;
      logic                  pin;
      logic                  oe;
      logic                  sync_a;
      logic                  sync_b;
      logic                  sync_prev;
      logic                  action;
      logic [7:0]            rdata;
   } sel_state_t;

   localparam sel_state_t STATE_RESET = '{func: FUNC_RESET, default: '0};

endpackage

// file: hw/mfp_output_select.sv
/*
 * Multifunction pin selector: a function byte picks one internal status
 * signal, a divided clock or a watchdog strobe to drive on the pin, or
 * turns the pin into an input that raises a control action.
 * Assumes all status inputs and the watchdog strobe come from logic on
 * clock_i; only the pin input is asynchronous.
 */
`timescale 1ns/1ns

module mfp_output_select
   import mfp_pkg::*;
#(
   parameter int ADDR_W = mfp_pkg::REG_ADDR_W
)(
   input  wire logic               clock_i,
   input  wire logic               reset_n_i,
   input  wire mfp_pkg::reg_req_t  reg_req_i,
   output logic [7:0]              reg_rdata_o,
   input  wire mfp_pkg::dev_status_t status_i,
   input  wire logic               wdog_expire_i,
   input  wire logic               pin_i,
   output logic                    pin_o,
   output logic                    pin_oe_o,
   output logic                    in_action_o,
   output logic [6:0]              in_function_o
);
   import mfp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   if (ADDR_W != REG_ADDR_W)
   begin : g_bad_addr
      $error("register address width must match the package map");
   end
   if (WDOG_PULSE_CYCLES >= (1 << WDOG_CNT_W))
   begin : g_bad_wdog
      $error("watchdog strobe counter too narrow");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // per-channel flag picked by the low nibble of a channel code
   function automatic logic chan_flag(input chan_status_t ch,
                                      input logic [3:0]   sel,
                                      input logic [3:0]   last);
      logic r;
      r = 1'b0;
      if (sel <= last)
      begin
         unique case (sel)
            4'h0:    r = ch.phase_lock;
            4'h1:    r = ch.freq_lock;
            4'h2:    r = ch.analog_lock;
            4'h3:    r = ch.analog_cal;
            4'h4:    r = ch.active;
            4'h5:    r = ch.free_run;
            4'h6:    r = ch.holdover;
            4'h7:    r = ch.switchover;
            4'h8:    r = ch.history_avail;
            4'h9:    r = ch.history_updated;
            4'hA:    r = ch.clamp_active;
            4'hB:    r = ch.slew_limited;
            4'hC:    r = ch.sync_pulse;
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // full lock of one channel: digital phase, analog loop, multiplier
   function automatic logic chan_locked(input chan_status_t ch, input logic mult);
      return ch.phase_lock & ch.analog_lock & mult;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   sel_state_t state_q;
   sel_state_t state_d;
   logic       level;
   logic       zero_lock;
   logic       one_lock;
   logic [3:0] ref_pick;

   assign zero_lock = chan_locked(status_i.chan_zero, status_i.mult_lock);
   assign one_lock  = chan_locked(status_i.chan_one, status_i.mult_lock);
   assign ref_pick  = 4'h1 << state_q.func[1:0];

   // pin level for the current function byte
   always_comb
   begin
      level = 1'b0;  // reserved codes stay low
      unique case (state_q.func)
         CODE_LOW:        level = 1'b0;
         CODE_HIGH:       level = 1'b1;
         CODE_DIV_CLK:    level = state_q.div_clk;
         CODE_WDOG:       level = (state_q.wd_cnt != '0);
         CODE_NVM_WRITE:  level = status_i.nvm_write_busy;
         CODE_NVM_READ:   level = status_i.nvm_read_busy;
         CODE_NVM_FAULT:  level = status_i.nvm_fault;
         CODE_MULT_LOCK:  level = status_i.mult_lock;
         CODE_MULT_STBL:  level = status_i.mult_stable;
         CODE_ALL_LOCK:   level = zero_lock & one_lock;
         CODE_ZERO_LOCK:  level = zero_lock;
         CODE_ONE_LOCK:   level = one_lock;
         CODE_IRQ_ANY:    level = status_i.irq_shared | status_i.irq_zero
                                  | status_i.irq_one;
         CODE_IRQ_SHARED: level = status_i.irq_shared;
         CODE_IRQ_ZERO:   level = status_i.irq_zero;
         CODE_IRQ_ONE:    level = status_i.irq_one;
         default:
         begin
            // grouped codes: references in steps of eight, channels by nibble
            if (state_q.func[7:3] == GROUP_REF_FAULT && !state_q.func[2])
               level = |(status_i.ref_fault & ref_pick);
            else if (state_q.func[7:3] == GROUP_REF_VALID && !state_q.func[2])
               level = |(status_i.ref_valid & ref_pick);
            else if (state_q.func[7:3] == GROUP_REF_ACT && !state_q.func[2])
               level = |((status_i.ref_active_zero | status_i.ref_active_one)
                         & ref_pick);
            else if (state_q.func[7:4] == GROUP_CHAN_ZERO)
               level = chan_flag(status_i.chan_zero, state_q.func[3:0],
                                 CHAN_ZERO_LAST);
            else if (state_q.func[7:4] == GROUP_CHAN_ONE)
               level = chan_flag(status_i.chan_one, state_q.func[3:0],
                                 CHAN_ONE_LAST);
            else
               level = 1'b0;
         end
      endcase
   end

   // next state: registers, divider, strobe, pin and input action
   always_comb
   begin
      state_d = state_q;

      // function byte write; a read never waits
      if (reg_req_i.write && reg_req_i.addr == REG_FUNC)
         state_d.func = reg_req_i.wdata;
      state_d.rdata = 8'h00;
      if (reg_req_i.read)
      begin
         unique case (reg_req_i.addr)
            REG_FUNC:      state_d.rdata = state_q.func;
            REG_PIN_STATE: state_d.rdata = {3'b000, state_q.sync_b,
                                            (state_q.wd_cnt != '0),
                                            state_q.div_clk, state_q.oe,
                                            state_q.pin};
            default:       state_d.rdata = 8'h00;
         endcase
      end

      // free-running divide by 32: toggle every half period
      if (state_q.div_cnt == DIV_CNT_W'(CLK_DIV_HALF - 1))
      begin
         state_d.div_cnt = '0;
         state_d.div_clk = ~state_q.div_clk;
      end
      else
         state_d.div_cnt = state_q.div_cnt + 1'b1;

      // watchdog strobe length; a fresh expiry restarts it
      if (wdog_expire_i)
         state_d.wd_cnt = WDOG_CNT_W'(WDOG_PULSE_CYCLES);
      else if (state_q.wd_cnt != '0)
         state_d.wd_cnt = state_q.wd_cnt - 1'b1;

      // drive only with the direction bit set
      state_d.oe  = state_q.func[DIRECTION_BIT];
      state_d.pin = state_q.func[DIRECTION_BIT] & level;

      // input direction: rising pin edge raises the action
      state_d.sync_a    = pin_i;
      state_d.sync_b    = state_q.sync_a;
      state_d.sync_prev = state_q.sync_b;
      state_d.action    = !state_q.func[DIRECTION_BIT]
                          && state_q.func[6:0] != IN_RESERVED
                          && state_q.sync_b && !state_q.sync_prev;
   end

   // one register for the whole state; synchronous reset
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
         state_q <= STATE_RESET;
      else
         state_q <= state_d;
   end

   assign pin_o         = state_q.pin;
   assign pin_oe_o      = state_q.oe;
   assign reg_rdata_o   = state_q.rdata;
   assign in_action_o   = state_q.action;
   assign in_function_o = state_q.func[6:0];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   // written direction bit reaches the enable two edges later
   property p_dir_enable;
      (reg_req_i.write && reg_req_i.addr == REG_FUNC) |=> ##1
         (pin_oe_o == $past(reg_req_i.wdata[DIRECTION_BIT], 2));
   endproperty
   a_dir_enable: assert property (p_dir_enable)
      else $error("pin enable does not follow direction bit");

   property p_static;
      (state_q.func == CODE_LOW |=> !pin_o) and (state_q.func == CODE_HIGH |=> pin_o);
   endproperty
   a_static: assert property (p_static)
      else $error("static level wrong");

   property p_div_period;
      (state_q.div_cnt == DIV_CNT_W'(CLK_DIV_HALF - 1)) |=>
         (state_q.div_clk != $past(state_q.div_clk)) ##1 $stable(state_q.div_clk)[*8];
   endproperty
   a_div_period: assert property (p_div_period)
      else $error("clock divider half period wrong");

   property p_div_pin;
      (state_q.func == CODE_DIV_CLK) |=> (pin_o == $past(state_q.div_clk));
   endproperty
   a_div_pin: assert property (p_div_pin)
      else $error("divided clock not on pin");

   property p_wdog_width;
      (state_q.func == CODE_WDOG && wdog_expire_i) ##1
         (state_q.func == CODE_WDOG && !wdog_expire_i)[*2] ##1
         (state_q.func == CODE_WDOG) |->
         $past(pin_o) && pin_o ##1 !pin_o;
   endproperty
   a_wdog_width: assert property (p_wdog_width)
      else $error("watchdog strobe not two cycles");

   property p_nvm;
      (state_q.func == CODE_NVM_WRITE |=> pin_o == $past(status_i.nvm_write_busy))
      and (state_q.func == CODE_NVM_FAULT |=> pin_o == $past(status_i.nvm_fault));
   endproperty
   a_nvm: assert property (p_nvm)
      else $error("nvm write or fault flag not on pin");

   property p_nvm_read;
      (state_q.func == CODE_NVM_READ) |=> (pin_o == $past(status_i.nvm_read_busy));
   endproperty
   a_nvm_read: assert property (p_nvm_read)
      else $error("nvm read flag not on pin");

   property p_mult;
      (state_q.func == CODE_MULT_STBL) |=> (pin_o == $past(status_i.mult_stable));
   endproperty
   a_mult: assert property (p_mult)
      else $error("multiplier stable flag not on pin");

   property p_zero_lock;
      (state_q.func == CODE_ZERO_LOCK) |=> (pin_o == ($past(status_i.chan_zero.phase_lock)
         && $past(status_i.chan_zero.analog_lock) && $past(status_i.mult_lock)));
   endproperty
   a_zero_lock: assert property (p_zero_lock)
      else $error("channel zero lock AND wrong");

   property p_ref_fault;
      (state_q.func == 8'hA1) |=> (pin_o == $past(status_i.ref_fault[1]));
   endproperty
   a_ref_fault: assert property (p_ref_fault)
      else $error("reference b fault not on pin");

   property p_ref_valid;
      (state_q.func == 8'hAA) |=> (pin_o == $past(status_i.ref_valid[2]));
   endproperty
   a_ref_valid: assert property (p_ref_valid)
      else $error("reference c valid not on pin");

   property p_freq_lock;
      (state_q.func == 8'hC1) |=> (pin_o == $past(status_i.chan_zero.freq_lock));
   endproperty
   a_freq_lock: assert property (p_freq_lock)
      else $error("channel zero frequency lock not on pin");

   property p_switchover;
      (state_q.func == 8'hC7) |=> (pin_o == $past(status_i.chan_zero.switchover));
   endproperty
   a_switchover: assert property (p_switchover)
      else $error("channel zero switchover not on pin");

   property p_clamp;
      (state_q.func == 8'hCA) |=> (pin_o == $past(status_i.chan_zero.clamp_active));
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("channel zero clamp not on pin");

   property p_hist_event;
      (state_q.func == 8'hC9) |=> (pin_o == $past(status_i.chan_zero.history_updated));
   endproperty
   a_hist_event: assert property (p_hist_event)
      else $error("channel zero history update not on pin");

   property p_sync_pulse;
      (state_q.func == 8'hCC) |=> (pin_o == $past(status_i.chan_zero.sync_pulse));
   endproperty
   a_sync_pulse: assert property (p_sync_pulse)
      else $error("channel zero sync pulse not on pin");

   property p_all_lock;
      (state_q.func == CODE_ALL_LOCK && !status_i.mult_lock) |=> !pin_o;
   endproperty
   a_all_lock: assert property (p_all_lock)
      else $error("all-locked high without multiplier lock");

   property p_irq_any;
      (state_q.func == CODE_IRQ_ANY && status_i.irq_one) |=> pin_o;
   endproperty
   a_irq_any: assert property (p_irq_any)
      else $error("interrupt OR misses channel one");

   property p_ref_act;
      (state_q.func == 8'hB3) |=>
         (pin_o == ($past(status_i.ref_active_zero[3]) | $past(status_i.ref_active_one[3])));
   endproperty
   a_ref_act: assert property (p_ref_act)
      else $error("reference d active OR wrong");

   property p_chan_one;
      (state_q.func == 8'hD6) |=> (pin_o == $past(status_i.chan_one.holdover));
   endproperty
   a_chan_one: assert property (p_chan_one)
      else $error("channel one holdover not on pin");

   property p_input_quiet;
      !state_q.func[DIRECTION_BIT] |=> !pin_oe_o && !pin_o;
   endproperty
   a_input_quiet: assert property (p_input_quiet)
      else $error("pin driven in input direction");

   property p_reserved;
      (state_q.func == 8'h87 || state_q.func == 8'hD8 || state_q.func == 8'hFF) |=> !pin_o;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved code drives high");

   property p_read_once;
      reg_req_i.read && reg_req_i.addr == REG_FUNC && !reg_req_i.write |=>
         (reg_rdata_o == $past(state_q.func)) ##1 ($past(reg_req_i.read) || reg_rdata_o == 8'h00);
   endproperty
   a_read_once: assert property (p_read_once)
      else $error("read data not one cycle");

endmodule // mfp_output_select

// file: verification/pin_board_model.sv
/*
 * Board-side model of the logic that watches the multifunction pin.
 * Assumes the device pin drive and enable come straight from its ports.
 */
`timescale 1ns/1ns

module pin_board_model (
   input  wire logic        clock_i,
   input  wire logic        dev_pin_i,
   input  wire logic        dev_oe_i,
   input  wire logic        drive_i,
   input  wire logic        drive_en_i,
   output logic             wire_o,
   output logic [15:0]      rise_cnt_o
);
   logic last_q = 1'b0;

   // wire level: the device wins, the board only drives into an input
   always_comb
   begin
      if (dev_oe_i)
         wire_o = dev_pin_i;
      else if (drive_en_i)
         wire_o = drive_i;
      else
         wire_o = ~last_q;  // floating line, no pull resistor on it
   end

   ////////////////////////////////////////////////////////////////////////////
   // count rising edges seen while the device drives, so a strobe is one pulse
   initial rise_cnt_o = 16'h0000;
   always @(posedge clock_i)
   begin
      if (dev_oe_i && wire_o && !last_q)
         rise_cnt_o <= rise_cnt_o + 16'h0001;
      last_q <= wire_o;
   end
endmodule // pin_board_model

// file: verification/tb_multifunction_pin_output_select.sv
/*
 * Self-checking bench for the multifunction pin output selector.
 * Assumes the selector and its package as declared, one 50 MHz clock.
 */
`timescale 1ns/1ns

module tb_multifunction_pin_output_select;
   import mfp_pkg::*;
   typedef struct { int kind; int due; logic [7:0] exp; logic [7:0] mask; } note_t;
   logic        clock_i, reset_n_i, wdog_expire_i, drive, pin_o, pin_oe_o, in_action_o, wire_lvl;
   logic [7:0]  reg_rdata_o, r0;
   logic [6:0]  in_function_o;
   logic [15:0] rises;
   logic [31:0] seed;
   logic [63:0] rr;
   reg_req_t    req;
   dev_status_t st, s;
   int          edge_n = 0, err_total = 0, n_tests = 0, k, p, c, div_ph = 0;
   note_t       q[$];

   mfp_output_select dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_req_i(req), .reg_rdata_o(reg_rdata_o),
      .status_i(st), .wdog_expire_i(wdog_expire_i), .pin_i(wire_lvl), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .in_action_o(in_action_o), .in_function_o(in_function_o));
   pin_board_model board (.clock_i(clock_i), .dev_pin_i(pin_o), .dev_oe_i(pin_oe_o),
      .drive_i(drive), .drive_en_i(1'b1), .wire_o(wire_lvl), .rise_cnt_o(rises));

   ////////////////////////////////////////////////////////////////////////////
   // clock and edge count, the time base of every note
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   always @(posedge clock_i) edge_n <= edge_n + 1;
   // divider phase counted from the last reset edge; the divider runs free from there
   always @(posedge clock_i) div_ph <= reset_n_i ? div_ph + 1 : 0;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // expected pin level for an output code, channel flags indexed from the top
   function automatic logic exp_pin(input logic [7:0] f, input dev_status_t v);
      logic [12:0] z;
      logic [12:0] o;
      logic        lz;
      logic        lo;
      z  = v.chan_zero;
      o  = v.chan_one;
      lz = z[12] & z[10] & v.mult_lock;
      lo = o[12] & o[10] & v.mult_lock;
      exp_pin = 1'b0;
      case (f)
         8'h81: exp_pin = 1'b1;
         8'h84: exp_pin = v.nvm_write_busy;
         8'h85: exp_pin = v.nvm_read_busy;
         8'h86: exp_pin = v.nvm_fault;
         8'h88: exp_pin = v.mult_lock;
         8'h89: exp_pin = v.mult_stable;
         8'h8A: exp_pin = lz & lo;
         8'h8B: exp_pin = lz;
         8'h8C: exp_pin = lo;
         8'h90: exp_pin = v.irq_shared | v.irq_zero | v.irq_one;
         8'h91: exp_pin = v.irq_shared;
         8'h92: exp_pin = v.irq_zero;
         8'h93: exp_pin = v.irq_one;
         default:
         begin
            if (f[7:2] == 6'h28)
               exp_pin = v.ref_fault[f[1:0]];
            if (f[7:2] == 6'h2A)
               exp_pin = v.ref_valid[f[1:0]];
            if (f[7:2] == 6'h2C)
               exp_pin = v.ref_active_zero[f[1:0]] | v.ref_active_one[f[1:0]];
            if (f[7:4] == 4'hC && f[3:0] <= 4'hC)
               exp_pin = z[4'hC - f[3:0]];
            if (f[7:3] == 5'h1A)
               exp_pin = o[4'hC - {1'b0, f[2:0]}];
         end
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // result checking: notes fall due a fixed number of edges after the driver
   task automatic check_bit(input string name, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %b seen %b", name, e, g);
      end
   endtask

   task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g,
                             input logic [7:0] m);
      n_tests++;
      if ((g & m) !== (e & m))
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, e & m, g & m);
      end
   endtask

   task automatic compare(input note_t n);
      case (n.kind)
         0: check_bit("pin_o", n.exp[0], pin_o);
         1: check_bit("pin_oe_o", n.exp[0], pin_oe_o);
         2: check_bit("in_action_o", n.exp[0], in_action_o);
         3: check_byte("reg_rdata_o", n.exp, reg_rdata_o, n.mask);
         default: check_byte("in_function_o", n.exp, {1'b0, in_function_o}, n.mask);
      endcase
   endtask

   initial
   begin
      forever
      begin
         @(posedge clock_i);
         #1;
         for (int i = q.size() - 1; i >= 0; i--)
            if (q[i].due <= edge_n)
            begin
               compare(q[i]);
               q.delete(i);
            end
      end
   end

   task automatic note(input int kind, input int d, input logic [7:0] e, input logic [7:0] m);
      note_t n;
      n.kind = kind;
      n.due  = edge_n + d;
      n.exp  = e;
      n.mask = m;
      q.push_back(n);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // register port master: signals change only by nonblocking at rising edges
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req.write <= w;
      req.read  <= r;
      req.addr  <= a;
      req.wdata <= d;
   endtask

   // new function byte and status together; the pin follows two edges later
   task automatic apply(input logic [7:0] f, input dev_status_t v);
      bus(1'b1, 1'b0, REG_FUNC, f);
      st <= v;
      if (f == CODE_DIV_CLK)
         note(0, 3, {7'h00, ((div_ph + 2) / CLK_DIV_HALF) % 2 == 1}, 8'hFF);
      else
         note(0, 3, {7'h00, exp_pin(f, v)}, 8'hFF);
      note(1, 3, 8'h01, 8'hFF);
      note(2, 3, 8'h00, 8'hFF);
      bus(1'b0, 1'b0, REG_FUNC, 8'h00);
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_n_i     = 1'b0;
      req           = '0;
      st            = '0;
      wdog_expire_i = 1'b0;
      drive         = 1'b0;
      seed          = 32'h044F;
      repeat (8) @(posedge clock_i);
      reset_n_i <= 1'b1;
      // registers: reset value, unmapped and read-only places, back-to-back access
      bus(1'b0, 1'b1, REG_FUNC, 8'h00);
      note(3, 2, 8'h80, 8'hFF);
      bus(1'b1, 1'b0, 4'h5, 8'h81);
      bus(1'b0, 1'b1, 4'h5, 8'h00);
      note(3, 2, 8'h00, 8'hFF);
      bus(1'b1, 1'b0, REG_PIN_STATE, 8'h81);
      bus(1'b1, 1'b0, REG_FUNC, 8'h81);
      bus(1'b0, 1'b1, REG_FUNC, 8'h00);
      note(3, 2, 8'h81, 8'hFF);
      bus(1'b0, 1'b0, REG_FUNC, 8'h00);
      note(3, 2, 8'h00, 8'hFF);
      repeat (4) @(posedge clock_i);
      bus(1'b0, 1'b1, REG_PIN_STATE, 8'h00);
      note(3, 2, 8'h13, 8'hFB);
      bus(1'b0, 1'b0, REG_FUNC, 8'h00);
      // every output code except 0x82 and 0x83: all flags set first, then random flags
      for (p = 0; p < 3; p++)
         for (c = 128; c < 256; c++)
            if (c != 130 && c != 131)
            begin
               seed = lfsr(seed);
               rr[63:32] = seed;
               seed = lfsr(seed);
               rr[31:0] = seed;
               s = rr[$bits(dev_status_t)-1:0];
               if (p == 0)
                  s = '1;
               apply(c[7:0], s);
            end
      // divided clock: half period of sixteen edges, phase taken from the pin
      apply(8'h82, s);
      @(posedge clock_i);
      #1;
      r0[0] = pin_o;
      k = 0;
      while (pin_o === r0[0] && k < 40)
      begin
         @(posedge clock_i);
         #1;
         k++;
      end
      if (k >= 40)
      begin
         err_total++;
         stop_test();
      end
      for (k = 1; k < 64; k++)
         note(0, k, {7'h00, pin_o ^ k[4]}, 8'hFF);
      repeat (66) @(posedge clock_i);
      // watchdog strobe: two cycles high, one rising edge seen by the board
      apply(8'h83, s);
      repeat (2) @(posedge clock_i);
      r0 = rises[7:0];
      wdog_expire_i <= 1'b1;
      for (k = 1; k < 7; k++)
         note(0, k, {7'h00, k == 3 || k == 4}, 8'hFF);
      @(posedge clock_i);
      wdog_expire_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      check_byte("strobe_count", 8'h01, rises[7:0] - r0, 8'hFF);
      // input direction: a rising pin raises one action, code zero raises none
      for (p = 1; p >= 0; p--)
      begin
         bus(1'b1, 1'b0, REG_FUNC, p[7:0]);
         note(1, 3, 8'h00, 8'hFF);
         note(4, 3, p[7:0], 8'h7F);
         bus(1'b0, 1'b0, REG_FUNC, 8'h00);
         repeat (4) @(posedge clock_i);
         drive <= 1'b1;
         for (k = 2; k < 8; k++)
            note(2, k, {7'h00, p == 1 && k == 4}, 8'hFF);
         repeat (8) @(posedge clock_i);
         drive <= 1'b0;
      end
      // second reset in mid-run brings the function byte back
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      @(posedge clock_i);
      reset_n_i <= 1'b1;
      bus(1'b0, 1'b1, REG_FUNC, 8'h00);
      note(3, 2, 8'h80, 8'hFF);
      note(1, 3, 8'h01, 8'hFF);
      note(4, 2, 8'h00, 8'h7F);
      bus(1'b0, 1'b0, REG_FUNC, 8'h00);
      repeat (8) @(posedge clock_i);
      stop_test();
   end
endmodule // tb_multifunction_pin_output_select
